/* dv/nac_properties.sv */
// port checker for nac_top
// assumes bind into nac_top, one clock, sync low reset
`default_nettype none
module nac_properties (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [3:0] wb_adr_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire logic global_irq_enable_in,
  input wire logic ready_irq_out,
  input wire logic stall_out
);
  logic [3:0] run_ff;
  logic [3:0] nxt_run;
  logic rd;
  // run of stall cycles, catches a halt that never ends
  always_comb nxt_run = stall_out ? run_ff + 4'h1 : 4'h0;
  always_ff @(posedge mclk_in) run_ff <= rst_n_in ? nxt_run : 4'h0;
  assign rd = wb_ack_out && !wb_we_in;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  ack_follows_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("ack late");
  ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack too long");
  irq_global_a: assert property (ready_irq_out |-> $past(global_irq_enable_in))
    else $error("irq without global enable");
  ctl_reserved_a: assert property (rd && wb_adr_in == 4'h0 |-> wb_dat_out[7:4] == 4'h0)
    else $error("reserved bits set");
  stall_bound_a: assert property (run_ff <= 4'h4) else $error("stall too long");
  unmapped_zero_a: assert property (rd && wb_adr_in[1:0] != 2'h0 |-> wb_dat_out == 32'h0)
    else $error("unmapped read not zero");
  addr_width_a: assert property (rd && wb_adr_in == 4'h4 |-> wb_dat_out[31:9] == 23'h0)
    else $error("address too wide");
  byte_width_a: assert property (rd && wb_adr_in == 4'h8 |-> wb_dat_out[31:8] == 24'h0)
    else $error("byte too wide");
  cover property (ready_irq_out);
  cover property (stall_out);
  cover property (wb_ack_out && wb_we_in);
endmodule // nac_properties
bind nac_top nac_properties chk (.*);
`default_nettype wire

/* dv/nac_top_bench.sv */
// self-checking bench for nac_top over classic wishbone
// assumes a fast oscillator tick to keep the write time short
`default_nettype none
`define CHK(g, w) begin checked++; if ((g) !== (w)) begin failures++; \
  $display("unexpected at %0t: got %h want %h", $time, g, w); end end
module nac_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc, stb, we, ack, gie, spe, irq, stall, oreq;
  logic tick = 1'b0;
  logic pdn = 1'b0;
  logic [3:0] adr;
  logic [31:0] wdat, rdat, q;
  int failures = 0;
  int checked = 0;
  always #20 clk = ~clk;
  // tick every other cycle: write takes 16896 cycles
  always @(posedge clk) tick <= ~tick;
  nac_top dut (.mclk_in(clk), .rst_n_in(rst_n), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wdat), .wb_dat_out(rdat),
    .wb_ack_out(ack), .osc_tick_in(tick), .global_irq_enable_in(gie),
    .self_prog_enable_in(spe), .power_down_in(pdn), .ready_irq_out(irq),
    .stall_out(stall), .osc_request_out(oreq));
  task close_out;
    if (failures == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // one classic cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    {cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, a, d};
    n = 0;
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 20);
    q = rdat;
    {cyc, stb} <= 2'b00;
    if (n >= 20) failures++;
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    do begin bus(0, 4'h0, 0); n++; end while (q[1] !== 1'b0 && n < 9000);
    if (n >= 9000) failures++;
  endtask
  task t_irq;
    gie <= 1'b1;
    bus(1, 4'h0, 32'hF8);
    bus(0, 4'h0, 0);
    `CHK(q[7:4], 4'h0)
    `CHK(irq, 1'b1)
    gie <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    bus(1, 4'h0, 0);
    gie <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    bus(0, 4'h1, 0);
    `CHK(q, 32'h0)
  endtask
  task t_refuse;
    bus(1, 4'h0, 32'h2);
    bus(0, 4'h0, 0);
    `CHK(q[1], 1'b0)
    bus(1, 4'h0, 32'h4);
    repeat (6) @(posedge clk);
    bus(0, 4'h0, 0);
    `CHK(q[2], 1'b0)
    bus(1, 4'h0, 32'h2);
    bus(0, 4'h0, 0);
    `CHK(q[1], 1'b0)
    spe <= 1'b1;
    bus(1, 4'h0, 32'h4);
    bus(1, 4'h0, 32'h2);
    bus(0, 4'h0, 0);
    `CHK(q[1], 1'b0)
    spe <= 1'b0;
  endtask
  // write across a mid-run reset, then read back through the read strobe
  task t_write;
    bus(1, 4'h4, 32'h1FF);
    bus(1, 4'h8, 32'hA5);
    gie <= 1'b0;
    bus(1, 4'h0, 32'hC);
    bus(1, 4'h0, 32'hA);
    gie <= 1'b1;
    bus(0, 4'hC, 0);
    `CHK(q[1:0], 2'h1)
    `CHK(irq, 1'b0)
    bus(1, 4'h4, 32'h3);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK(oreq, 1'b1)
    rst_n <= 1'b1;
    bus(0, 4'hC, 0);
    `CHK(q[0], 1'b1)
    pdn <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK(oreq, 1'b1)
    wait_idle();
    `CHK(oreq, 1'b1)
    pdn <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(oreq, 1'b0)
    pdn <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK(oreq, 1'b0)
    pdn <= 1'b0;
    bus(1, 4'h8, 32'h5A);
    bus(1, 4'h0, 32'h1);
    bus(0, 4'h8, 0);
    `CHK(q, 32'hA5)
    bus(0, 4'h4, 0);
    `CHK(q, 32'h1FF)
  endtask
  initial begin
    {cyc, stb, we, adr, wdat, gie, spe} = '0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_irq();
    t_refuse();
    t_write();
    close_out();
  end
  initial begin
    #3600000;
    failures++;
    close_out();
  end
endmodule // nac_top_bench
`default_nettype wire

/* logic/nac_params.svh */
// constants for the nonvolatile access control block
// assumes inclusion by logic/nac_top.sv only; logic/nac_pkg.sv does not include it
`ifndef NAC_PARAMS_SVH
`define NAC_PARAMS_SVH
// register offsets (byte addresses, one aligned word each)
`define NAC_OFS_CONTROL 4'h0
`define NAC_OFS_ADDRESS 4'h4
`define NAC_OFS_BYTE 4'h8
`define NAC_OFS_STATUS 4'hC
// control field positions
`define NAC_BIT_READ 0
`define NAC_BIT_STROBE 1
`define NAC_BIT_ARM 2
`define NAC_BIT_RIE 3
// status field positions
`define NAC_BIT_BUSY 0
`define NAC_BIT_SELFPROG 1
`define NAC_BIT_IRQ 2
// timing
`define NAC_ARM_CYCLES 3'h4
`define NAC_WRITE_STALL 3'h2
`define NAC_READ_STALL 3'h4
`define NAC_OSC_CYCLES 14'h2100
`define NAC_MEM_WORDS 512
`endif

/* logic/nac_pkg.sv */
// types shared by the nonvolatile access control block
// assumes logic/nac_params.svh is present beside it
`default_nettype none
package nac_pkg;
  typedef enum logic [1:0] {
    NAC_IDLE,
    NAC_WRITING,
    NAC_FINISH
  } nac_state_e;
  typedef logic [8:0] nac_addr_t;
endpackage
`default_nettype wire

/* logic/nac_top.sv */
// control logic for byte access to a 512-byte data store, wishbone slave
// assumes one 25 MHz clock, a 1 MHz oscillator tick input synchronous to it,
// and a cpu that honours stall_out
//
// Summary of operation
// - control bits seven to four read zero
// - ready irq needs enable and global enable
// - ready irq is a level while strobe clear
// - write starts if strobe within four cycles
// - strobe without arm is ignored
// - arm clears itself four cycles later
// - no write while flash self-programming
// - strobe clears when write time elapses
// - strobe stalls cpu two cycles
// - read strobe fetches byte immediately
// - read stalls cpu four cycles
// - no read or address change while writing
// - write lasts 8448 oscillator cycles
// - write timed by 1 MHz oscillator
// - write completes through power-down, oscillator on
// - reset does not abort a write
// - nine-bit address, zero to 511
// - byte register holds write and read data
`include "nac_params.svh"
`default_nettype none
module nac_top
  import nac_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [3:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic osc_tick_in,
  input wire logic global_irq_enable_in,
  input wire logic self_prog_enable_in,
  input wire logic power_down_in,
  output logic ready_irq_out,
  output logic stall_out,
  output logic osc_request_out
);

  // ------------------------------------------------------------------
  // storage and state
  // ------------------------------------------------------------------
  logic [7:0] mem_ff [`NAC_MEM_WORDS];
  // write engine flops start defined at power-up and are never reset
  nac_state_e state_ff = NAC_IDLE;
  nac_state_e nxt_state;
  nac_addr_t addr_ff, nxt_addr;
  logic [7:0] byte_ff, nxt_byte;
  logic rie_ff, nxt_rie;
  logic arm_ff, nxt_arm;
  logic strobe_ff = 1'b0;
  logic nxt_strobe;
  logic [2:0] arm_cnt_ff, nxt_arm_cnt;
  logic [2:0] stall_cnt_ff, nxt_stall_cnt;
  logic [13:0] osc_cnt_ff = 14'h0;
  logic [13:0] nxt_osc_cnt;
  logic ack_ff, nxt_ack;
  logic [31:0] rdat_ff, nxt_rdat;
  logic irq_ff, nxt_irq;
  logic stall_ff, nxt_stall;
  logic oscreq_ff = 1'b0;
  logic nxt_oscreq;
  logic mem_we;
  logic wr_ctl, wr_adr, wr_byte;
  logic busy;

  // decode one offset against the current access, lane 0 must be selected
  function automatic logic hit(input logic [3:0] ofs);
    hit = wb_cyc_in && wb_stb_in && wb_we_in && !ack_ff && wb_sel_in[0]
          && (wb_adr_in == ofs);
  endfunction

  // ------------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------------
  // one combinational block keeps every interlock in one place
  always_comb begin
    nxt_state = state_ff;
    nxt_addr = addr_ff;
    nxt_byte = byte_ff;
    nxt_rie = rie_ff;
    nxt_arm = arm_ff;
    nxt_strobe = strobe_ff;
    nxt_arm_cnt = arm_cnt_ff;
    nxt_stall_cnt = (stall_cnt_ff != 3'h0) ? stall_cnt_ff - 3'h1 : 3'h0;
    nxt_osc_cnt = osc_cnt_ff;
    nxt_ack = 1'b0;
    nxt_rdat = rdat_ff;
    mem_we = 1'b0;
    busy = (state_ff != NAC_IDLE);
    wr_ctl = hit(`NAC_OFS_CONTROL);
    wr_adr = hit(`NAC_OFS_ADDRESS);
    wr_byte = hit(`NAC_OFS_BYTE);

    // arm window countdown
    if (arm_ff) begin
      if (arm_cnt_ff == `NAC_ARM_CYCLES - 3'h1) begin
        nxt_arm = 1'b0;
        nxt_arm_cnt = 3'h0;
      end else begin
        nxt_arm_cnt = arm_cnt_ff + 3'h1;
      end
    end

    // data path registers: frozen while a write runs
    if (wr_adr && !busy) begin
      nxt_addr = wb_dat_in[8:0];
    end
    if (wr_byte && !busy) begin
      nxt_byte = wb_dat_in[7:0];
    end

    // control register write
    if (wr_ctl) begin
      nxt_rie = wb_dat_in[`NAC_BIT_RIE];
      if (wb_dat_in[`NAC_BIT_ARM] && !wb_dat_in[`NAC_BIT_STROBE]) begin
        nxt_arm = 1'b1;
        nxt_arm_cnt = 3'h0;
      end
      if (wb_dat_in[`NAC_BIT_STROBE] && arm_ff && !busy
          && !self_prog_enable_in) begin
        nxt_strobe = 1'b1;
        nxt_arm = 1'b0;
        nxt_state = NAC_WRITING;
        nxt_osc_cnt = 14'h0;
        nxt_stall_cnt = `NAC_WRITE_STALL;
      end else if (wb_dat_in[`NAC_BIT_READ] && !busy) begin
        nxt_byte = mem_ff[addr_ff];
        nxt_stall_cnt = `NAC_READ_STALL;
      end
    end

    // write timing on oscillator ticks, reset-proof counter
    case (state_ff)
      NAC_IDLE: begin
      end
      NAC_WRITING: begin
        if (osc_tick_in) begin
          if (osc_cnt_ff == `NAC_OSC_CYCLES - 14'h1) begin
            nxt_state = NAC_FINISH;
          end else begin
            nxt_osc_cnt = osc_cnt_ff + 14'h1;
          end
        end
      end
      NAC_FINISH: begin
        mem_we = 1'b1;
        nxt_strobe = 1'b0;
        nxt_state = NAC_IDLE;
      end
      default: nxt_state = NAC_IDLE;
    endcase

    // bus answer one cycle after the request
    if (wb_cyc_in && wb_stb_in && !ack_ff) begin
      nxt_ack = 1'b1;
      case (wb_adr_in)
        `NAC_OFS_CONTROL: nxt_rdat = {28'h0, rie_ff, arm_ff, strobe_ff, 1'b0};
        `NAC_OFS_ADDRESS: nxt_rdat = {23'h0, addr_ff};
        `NAC_OFS_BYTE: nxt_rdat = {24'h0, byte_ff};
        `NAC_OFS_STATUS: nxt_rdat = {29'h0, irq_ff, self_prog_enable_in, busy};
        default: nxt_rdat = 32'h0;
      endcase
    end

    nxt_irq = rie_ff && global_irq_enable_in && !strobe_ff;
    nxt_stall = (nxt_stall_cnt != 3'h0);
    // oscillator kept on through power-down while writing and after it
    nxt_oscreq = (nxt_state != NAC_IDLE) || (oscreq_ff && power_down_in);
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  // write engine state ignores reset so a running write finishes
  always_ff @(posedge mclk_in) begin
    state_ff <= nxt_state;
    osc_cnt_ff <= nxt_osc_cnt;
    strobe_ff <= nxt_strobe;
    // oscillator request must survive reset or a running write would starve
    oscreq_ff <= nxt_oscreq;
    addr_ff <= nxt_addr;
    byte_ff <= nxt_byte;
    if (mem_we) begin
      mem_ff[addr_ff] <= byte_ff;
    end
    if (!rst_n_in) begin
      rie_ff <= 1'b0;
      arm_ff <= 1'b0;
      arm_cnt_ff <= 3'h0;
      stall_cnt_ff <= 3'h0;
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0;
      irq_ff <= 1'b0;
      stall_ff <= 1'b0;
    end else begin
      rie_ff <= nxt_rie;
      arm_ff <= nxt_arm;
      arm_cnt_ff <= nxt_arm_cnt;
      stall_cnt_ff <= nxt_stall_cnt;
      ack_ff <= nxt_ack;
      rdat_ff <= nxt_rdat;
      irq_ff <= nxt_irq;
      stall_ff <= nxt_stall;
    end
  end

  assign wb_dat_out = rdat_ff;
  assign wb_ack_out = ack_ff;
  assign ready_irq_out = irq_ff;
  assign stall_out = stall_ff;
  assign osc_request_out = oscreq_ff;

endmodule // nac_top
`default_nettype wire
